// ### rtl/qdsc_bank.sv
// qdsc_bank: holding and active code/span buffers for every channel
// assumes: write, update and clear strobes come from the control logic on clock
`timescale 1ns/1ps
module qdsc_bank
  import qdsc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [qdsc_pkg::CHANNELS-1:0] wr_code,
  input wire logic [qdsc_pkg::CHANNELS-1:0] wr_span,
  input wire logic [qdsc_pkg::CODE_W-1:0] wr_data,
  input wire logic [qdsc_pkg::CHANNELS-1:0] upd,
  input wire logic clr,
  output logic [qdsc_pkg::CHANNELS*qdsc_pkg::CODE_W-1:0] hold_code,
  output logic [qdsc_pkg::CHANNELS*qdsc_pkg::SPAN_W-1:0] hold_span,
  output logic [qdsc_pkg::CHANNELS*qdsc_pkg::CODE_W-1:0] act_code,
  output logic [qdsc_pkg::CHANNELS*qdsc_pkg::SPAN_W-1:0] act_span
);
  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++) begin : g_ch
      logic [CODE_W-1:0] hc_r, hc_nxt, ac_r, ac_nxt;
      logic [SPAN_W-1:0] hs_r, hs_nxt, as_r, as_nxt;
      // writes touch the holding buffer only; active takes a copy on update
      always_comb begin
        hc_nxt = wr_code[c] ? wr_data : hc_r;
        hs_nxt = wr_span[c] ? wr_data[SPAN_W-1:0] : hs_r;
        ac_nxt = upd[c] ? hc_nxt : ac_r;
        as_nxt = upd[c] ? hs_nxt : as_r;
        if (clr) begin
          ac_nxt = '0;
          as_nxt = '0;
        end
      end
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          hc_r <= '0;
          hs_r <= '0;
          ac_r <= '0;
          as_r <= '0;
        end else begin
          hc_r <= hc_nxt;
          hs_r <= hs_nxt;
          ac_r <= ac_nxt;
          as_r <= as_nxt;
        end
      end
      assign hold_code[c*CODE_W +: CODE_W] = hc_r;
      assign hold_span[c*SPAN_W +: SPAN_W] = hs_r;
      assign act_code[c*CODE_W +: CODE_W] = ac_r;
      assign act_span[c*SPAN_W +: SPAN_W] = as_r;
    end
  endgenerate
endmodule

// ### rtl/qdsc_pkg.sv
// qdsc_pkg: shared constants for the quad dac serial control block
// assumes: included before every other qdsc design file
package qdsc_pkg;
  localparam int CHANNELS = 4;
  localparam int CODE_W = 16;
  localparam int SPAN_W = 4;
  localparam int FRAME_BITS = 24;
  localparam int PREFIX_BITS = 8;
  localparam int HEADER_BITS = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;
  localparam logic [7:0] OFS_CODE0 = 8'h10;
  localparam logic [7:0] OFS_SPAN0 = 8'h20;
  // status / mask bit positions
  localparam int EV_FRAME = 0;
  localparam int EV_UPDATE = 1;
  localparam int EV_CLEAR = 2;
  localparam int EV_W = 3;
  // state register fields
  localparam int ST_FLAG = 0;
  localparam int ST_SELECT = 1;
  localparam int ST_SLEEP_LSB = 4;
  // reset values
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;
  // pin synchroniser order and reset levels
  localparam int PIN_W = 5;
  localparam logic [PIN_W-1:0] PIN_RST = 5'h1C;
  localparam int PIN_SCLK = 0;
  localparam int PIN_SDI = 1;
  localparam int PIN_SEL = 2;
  localparam int PIN_UPD = 3;
  localparam int PIN_CLR = 4;
  // readback pointer kinds
  typedef enum logic [1:0] {
    QDSC_B1_SPAN = 2'h0,
    QDSC_B1_CODE = 2'h1,
    QDSC_B2_SPAN = 2'h2,
    QDSC_B2_CODE = 2'h3
  } qdsc_kind_t;
  // command field codes
  localparam logic [3:0] CMD_WR_SPAN = 4'h2;
  localparam logic [3:0] CMD_WR_CODE = 4'h3;
  localparam logic [3:0] CMD_UPD_N = 4'h4;
  localparam logic [3:0] CMD_UPD_ALL = 4'h5;
  localparam logic [3:0] CMD_WRS_UPD_N = 4'h6;
  localparam logic [3:0] CMD_WRC_UPD_N = 4'h7;
  localparam logic [3:0] CMD_WRS_UPD_ALL = 4'h8;
  localparam logic [3:0] CMD_WRC_UPD_ALL = 4'h9;
  localparam logic [3:0] CMD_RD_B1_SPAN = 4'hA;
  localparam logic [3:0] CMD_RD_B1_CODE = 4'hB;
  localparam logic [3:0] CMD_RD_B2_SPAN = 4'hC;
  localparam logic [3:0] CMD_RD_B2_CODE = 4'hD;
  localparam logic [3:0] CMD_SLEEP = 4'hE;
  localparam logic [3:0] CMD_NOP = 4'hF;
endpackage

// ### rtl/qdsc_sync.sv
// qdsc_sync: two flip-flop synchroniser, one per pin
// assumes: pins are asynchronous to clock; reset levels are constants
`timescale 1ns/1ps
module qdsc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);
  genvar i;
  // first stage feeds only the second stage
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic meta_nxt;
      logic sync_r;
      logic sync_nxt;
      always_comb begin
        meta_nxt = pin_in[i];
        sync_nxt = meta_r;
      end
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          meta_r <= RST_VAL[i];
          sync_r <= RST_VAL[i];
        end else begin
          meta_r <= meta_nxt;
          sync_r <= sync_nxt;
        end
      end
      assign pin_sync[i] = sync_r;
    end
  endgenerate
endmodule

// ### rtl/qdsc_top.sv
// qdsc_top: serial control front end of a quad dac with readback
// assumes: serial and async pins arrive from outside the clock domain;
// the register port is driven by logic on clock
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps

// Contract
// - While select is low each rising serial clock edge captures one serial input bit.
// - While select is low the readback output changes only on falling serial clock edges.
// - Readback bits start only after the last address bit has been captured.
// - The host frames a transfer with select low and the command runs when select rises.
// - While the async update input is low all holding buffers copy into the active buffers.
// - While the async clear input is low all active codes and spans are forced to zero.
// - The reset flag goes low after power-on reset and after any clear.
// - The reset flag goes high when an update executes and stays high until reset or clear.
// - A frame is 24 bits msb first: command nibble, address nibble, 16 data bits.
// - Readback is released while select is high and driven low until readback data starts.
// - Writes change holding buffers only; active buffers change only by an update copy or a clear.
module qdsc_top
  import qdsc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic select_load_n,
  input wire logic async_update_n,
  input wire logic async_clear_n,
  output logic readback_out,
  output logic readback_oe,
  output logic reset_flag_n,
  output logic irq,
  input wire logic [qdsc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [qdsc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [qdsc_pkg::DATA_W-1:0] reg_rdata
);
  import qdsc_pkg::*;

  // the two-bit channel index and the 16-bit readback word assume these sizes
  if ((CHANNELS != 4) || (CODE_W != 16) || (SPAN_W != 4)) begin : g_size_check
    $error("qdsc_top: unsupported channel count or field width");
  end

  logic [PIN_W-1:0] pins;
  logic sclk_s, sdi_s, sel_n_s, upd_n_s, clr_n_s;
  logic sclk_d_r, sclk_d_nxt, sel_d_r, sel_d_nxt;
  logic sclk_rise, sclk_fall, sel_fall, sel_rise;

  // every pin passes two flip-flops before use
  qdsc_sync #(.WIDTH(PIN_W), .RST_VAL(PIN_RST)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .pin_in({async_clear_n, async_update_n, select_load_n, serial_in, serial_clk}),
    .pin_sync(pins)
  );
  assign sclk_s = pins[PIN_SCLK];
  assign sdi_s = pins[PIN_SDI];
  assign sel_n_s = pins[PIN_SEL];
  assign upd_n_s = pins[PIN_UPD];
  assign clr_n_s = pins[PIN_CLR];

  // edge detection on the synchronised serial clock and select
  always_comb begin
    sclk_d_nxt = sclk_s;
    sel_d_nxt = sel_n_s;
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sclk_d_r <= 1'b0;
      sel_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_d_nxt;
      sel_d_r <= sel_d_nxt;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_d_r & ~sel_n_s;
  assign sclk_fall = ~sclk_s & sclk_d_r & ~sel_n_s;
  assign sel_fall = ~sel_n_s & sel_d_r;
  assign sel_rise = sel_n_s & ~sel_d_r;

  // buffer bank
  logic [CHANNELS-1:0] wr_code, wr_span, upd;
  logic [CODE_W-1:0] wr_data;
  logic [CHANNELS*CODE_W-1:0] hold_code, act_code;
  logic [CHANNELS*SPAN_W-1:0] hold_span, act_span;
  qdsc_bank u_bank (
    .clock(clock),
    .reset_n(reset_n),
    .wr_code(wr_code),
    .wr_span(wr_span),
    .wr_data(wr_data),
    .upd(upd),
    .clr(~clr_n_s),
    .hold_code(hold_code),
    .hold_span(hold_span),
    .act_code(act_code),
    .act_span(act_span)
  );

  // picks the 16-bit readback word of one buffer of one channel
  function automatic logic [CODE_W-1:0] rb_word(input qdsc_kind_t k, input logic [1:0] ch,
                                                input logic [CHANNELS-1:0] slp);
    logic [CODE_W-1:0] w;
    w = '0;
    case (k)
      QDSC_B1_SPAN: w = {11'h000, slp[ch], hold_span[ch*SPAN_W +: SPAN_W]};
      QDSC_B1_CODE: w = hold_code[ch*CODE_W +: CODE_W];
      QDSC_B2_SPAN: w = {11'h000, slp[ch], act_span[ch*SPAN_W +: SPAN_W]};
      QDSC_B2_CODE: w = act_code[ch*CODE_W +: CODE_W];
      default: w = '0;
    endcase
    return w;
  endfunction

  // serial shift, readback and frame decode state
  logic [FRAME_BITS-1:0] sh_r, sh_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic prefix_r, prefix_nxt;
  logic [CODE_W-1:0] rb_r, rb_nxt;
  logic armed_r, armed_nxt;
  logic out_r, out_nxt, oe_r, oe_nxt;
  qdsc_kind_t ptr_kind_r, ptr_kind_nxt;
  logic [1:0] ptr_ch_r, ptr_ch_nxt;
  logic [CHANNELS-1:0] sleep_r, sleep_nxt;
  logic flag_r, flag_nxt;
  logic ev_frame, ev_update;
  logic [FRAME_BITS-1:0] new_sh;
  logic [3:0] h_cmd, h_addr, cmd, addr;
  logic [1:0] ch;
  logic addr_ok, is_read, hdr_now;
  logic [CHANNELS-1:0] one_ch;

  assign new_sh = {sh_r[FRAME_BITS-2:0], sdi_s};
  assign h_cmd = new_sh[7:4];
  assign h_addr = new_sh[3:0];
  assign cmd = sh_r[FRAME_BITS-1 -: 4];
  assign addr = sh_r[FRAME_BITS-5 -: 4];
  assign ch = addr[1:0];
  assign addr_ok = (addr[3:2] == 2'h0);
  assign one_ch = addr_ok ? (CHANNELS'(1) << ch) : '0;
  assign is_read = (h_cmd >= CMD_RD_B1_SPAN) && (h_cmd <= CMD_RD_B2_CODE);
  // header is complete at bit 8, or at bit 16 after an all-zero leading byte
  assign hdr_now = sclk_rise && (((cnt_nxt == 6'(HEADER_BITS)) && (h_cmd != 4'h0))
                   || ((cnt_nxt == 6'(PREFIX_BITS + HEADER_BITS)) && prefix_r));

  always_comb begin
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    prefix_nxt = prefix_r;
    rb_nxt = rb_r;
    armed_nxt = armed_r;
    out_nxt = out_r;
    oe_nxt = ~sel_n_s;
    ptr_kind_nxt = ptr_kind_r;
    ptr_ch_nxt = ptr_ch_r;
    sleep_nxt = sleep_r;
    flag_nxt = flag_r;
    wr_code = '0;
    wr_span = '0;
    wr_data = sh_r[CODE_W-1:0];
    upd = '0;
    ev_frame = 1'b0;
    ev_update = 1'b0;
    if (sel_fall) begin
      cnt_nxt = '0;
      prefix_nxt = 1'b0;
      armed_nxt = 1'b0;
      out_nxt = 1'b0;
    end else if (sel_n_s) begin
      out_nxt = 1'b0;
      armed_nxt = 1'b0;
    end
    if (sclk_rise) begin
      sh_nxt = new_sh;
      cnt_nxt = (cnt_r == 6'h3F) ? cnt_r : cnt_r + 6'h01;
      if ((cnt_nxt == 6'(HEADER_BITS)) && (new_sh[7:0] == 8'h00))
        prefix_nxt = 1'b1;
    end
    if (hdr_now) begin
      // read commands show their own buffer, others the previous pointer
      armed_nxt = 1'b1;
      if (is_read)
        rb_nxt = rb_word(qdsc_kind_t'(h_cmd[1:0] ^ 2'h2), h_addr[1:0], sleep_r);
      else
        rb_nxt = rb_word(ptr_kind_r, ptr_ch_r, sleep_r);
    end
    if (sclk_fall && armed_r) begin
      out_nxt = rb_r[CODE_W-1];
      rb_nxt = {rb_r[CODE_W-2:0], 1'b0};
    end
    // decode the last 24 bits when select returns high
    if (sel_rise && (cnt_r >= 6'(FRAME_BITS)) && addr_ok) begin
      ev_frame = 1'b1;
      ptr_ch_nxt = ch;
      case (cmd)
        CMD_WR_SPAN: begin
          wr_span = one_ch;
          ptr_kind_nxt = QDSC_B1_SPAN;
        end
        CMD_WR_CODE: begin
          wr_code = one_ch;
          ptr_kind_nxt = QDSC_B1_CODE;
        end
        CMD_UPD_N: begin
          upd = one_ch;
          ptr_kind_nxt = QDSC_B2_SPAN;
        end
        CMD_UPD_ALL: begin
          upd = '1;
          ptr_kind_nxt = QDSC_B2_CODE;
          ptr_ch_nxt = 2'h0;
        end
        CMD_WRS_UPD_N: begin
          wr_span = one_ch;
          upd = one_ch;
          ptr_kind_nxt = QDSC_B2_SPAN;
        end
        CMD_WRC_UPD_N: begin
          wr_code = one_ch;
          upd = one_ch;
          ptr_kind_nxt = QDSC_B2_CODE;
        end
        CMD_WRS_UPD_ALL: begin
          wr_span = one_ch;
          upd = '1;
          ptr_kind_nxt = QDSC_B2_SPAN;
        end
        CMD_WRC_UPD_ALL: begin
          wr_code = one_ch;
          upd = '1;
          ptr_kind_nxt = QDSC_B2_CODE;
        end
        CMD_RD_B1_SPAN, CMD_RD_B1_CODE, CMD_RD_B2_SPAN, CMD_RD_B2_CODE: begin
          ptr_kind_nxt = qdsc_kind_t'(cmd[1:0] ^ 2'h2);
        end
        CMD_SLEEP: begin
          sleep_nxt = sleep_r | one_ch;
          ptr_kind_nxt = QDSC_B2_SPAN;
        end
        CMD_NOP: ptr_kind_nxt = QDSC_B2_CODE;
        // reserved codes leave the pointer alone and raise no event
        default: begin
          ev_frame = 1'b0;
          ptr_ch_nxt = ptr_ch_r;
        end
      endcase
    end
    if (!upd_n_s)
      upd = '1;
    if (upd != '0) begin
      ev_update = 1'b1;
      sleep_nxt = sleep_nxt & ~upd;
      flag_nxt = 1'b1;
    end
    if (!clr_n_s)
      flag_nxt = 1'b0;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sh_r <= '0;
      cnt_r <= '0;
      prefix_r <= 1'b0;
      rb_r <= '0;
      armed_r <= 1'b0;
      out_r <= 1'b0;
      oe_r <= 1'b0;
      ptr_kind_r <= QDSC_B2_CODE;
      ptr_ch_r <= 2'h0;
      sleep_r <= '0;
      flag_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      prefix_r <= prefix_nxt;
      rb_r <= rb_nxt;
      armed_r <= armed_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      ptr_kind_r <= ptr_kind_nxt;
      ptr_ch_r <= ptr_ch_nxt;
      sleep_r <= sleep_nxt;
      flag_r <= flag_nxt;
    end
  end
  assign readback_out = out_r;
  assign readback_oe = oe_r;
  assign reset_flag_n = flag_r;

  // status, mask, interrupt and register read port
  logic [EV_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
  logic irq_r, irq_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [1:0] ridx;
  assign ev = {~clr_n_s, ev_update, ev_frame};
  assign ridx = reg_addr[3:2];

  always_comb begin
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    rdata_nxt = '0;
    // a write of one clears; a new event in the same cycle wins
    if (reg_wr && (reg_addr == OFS_STATUS))
      stat_nxt = stat_r & ~reg_wdata[EV_W-1:0];
    if (reg_wr && (reg_addr == OFS_MASK))
      mask_nxt = reg_wdata[EV_W-1:0];
    stat_nxt = stat_nxt | ev;
    irq_nxt = |(stat_nxt & mask_nxt);
    if (reg_rd) begin
      if (reg_addr == OFS_STATUS)
        rdata_nxt = DATA_W'(stat_r);
      else if (reg_addr == OFS_MASK)
        rdata_nxt = DATA_W'(mask_r);
      else if (reg_addr == OFS_STATE)
        rdata_nxt = DATA_W'({sleep_r, 2'h0, sel_n_s, flag_r});
      // upper nibble picks code or span, bits 3:2 pick the channel
      else if ((reg_addr[7:4] == OFS_CODE0[7:4]) && (reg_addr[1:0] == 2'h0))
        rdata_nxt = DATA_W'(act_code[ridx*CODE_W +: CODE_W]);
      else if ((reg_addr[7:4] == OFS_SPAN0[7:4]) && (reg_addr[1:0] == 2'h0))
        rdata_nxt = DATA_W'(act_span[ridx*SPAN_W +: SPAN_W]);
      else
        rdata_nxt = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stat_r <= '0;
      mask_r <= MASK_RST;
      irq_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign irq = irq_r;
  assign reg_rdata = rdata_r;
endmodule

// ### verification/qdsc_host_model.sv
// qdsc_host_model: serial master that frames, shifts and captures readback
// assumes: the bench calls frame one at a time; serial clock idles low
`timescale 1ns/1ps
module qdsc_host_model (
  output logic serial_clk,
  output logic serial_in,
  output logic select_load_n,
  input wire logic readback_out,
  input wire logic readback_oe
);
  wire rb_pin;

  // three-state readback pin as the host sees it
  assign rb_pin = readback_oe ? readback_out : 1'bz;

  // idle levels at time zero
  initial begin
    serial_clk = 1'b0;
    serial_in = 1'b0;
    select_load_n = 1'b1;
  end

  // one frame of n bits, msb first; last 16 rises capture readback
  task automatic frame(input logic [31:0] w, input int n, output logic [15:0] rb);
    rb = 16'h0000;
    select_load_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #62.5 serial_clk = 1'b1;
      if (i < 16)
        rb = {rb[14:0], rb_pin};
      #62.5 serial_clk = 1'b0;
    end
    #62.5 select_load_n = 1'b1;
    serial_in = ~serial_in; // released line shows no stale bit
    #250;
  endtask
endmodule

// ### verification/qdsc_top_sva.sv
// qdsc_top_sva: concurrent checks on the quad dac serial control ports
// assumes: bound to qdsc_top; pins are sampled once on clock, as the design does
`timescale 1ns/1ps
module qdsc_top_sva
  import qdsc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic serial_clk,
  input wire logic select_load_n,
  input wire logic async_update_n,
  input wire logic async_clear_n,
  input wire logic readback_out,
  input wire logic readback_oe,
  input wire logic reset_flag_n,
  input wire logic reg_rd,
  input wire logic [qdsc_pkg::DATA_W-1:0] reg_rdata
);
  logic sclk_r, sclk_nxt;
  logic [3:0] since_fall_r, since_fall_nxt;
  logic [5:0] rises_r, rises_nxt;

  // cycles since the last serial clock fall, and rises within the frame
  always_comb begin
    sclk_nxt = serial_clk;
    since_fall_nxt = (since_fall_r == 4'hF) ? since_fall_r : since_fall_r + 4'h1;
    if (sclk_r && !serial_clk)
      since_fall_nxt = 4'h0;
    rises_nxt = rises_r;
    if (select_load_n)
      rises_nxt = 6'h00;
    else if (!sclk_r && serial_clk)
      rises_nxt = rises_r + 6'h01;
  end

  // register the edge trackers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sclk_r <= 1'b0;
      since_fall_r <= 4'hF;
      rises_r <= 6'h00;
    end else begin
      sclk_r <= sclk_nxt;
      since_fall_r <= since_fall_nxt;
      rises_r <= rises_nxt;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence frame_open_s;
    $fell(select_load_n);
  endsequence
  sequence rb_idle_s;
    readback_oe && !readback_out;
  endsequence

  a_oe_opens: assert property (frame_open_s |-> ##[2:5] rb_idle_s)
    else $error("readback not driven low after frame start");
  a_oe_closes: assert property ($rose(select_load_n) |-> ##[2:5] !readback_oe)
    else $error("readback still driven after frame end");
  a_oe_idle: assert property (select_load_n [*6] |-> !readback_oe && !readback_out)
    else $error("readback driven while not selected");
  a_rb_on_fall: assert property (readback_oe && $past(readback_oe) && $changed(readback_out)
      |-> since_fall_r inside {[1:6]})
    else $error("readback changed away from a serial clock fall");
  a_rb_after_addr: assert property (readback_out && !select_load_n |-> rises_r >= 6'h08)
    else $error("readback data before the address was captured");
  a_clear_flag: assert property ($fell(async_clear_n) |-> ##[1:5] !reset_flag_n)
    else $error("flag not lowered by clear");
  a_clear_holds: assert property ((!async_clear_n) [*6] |-> !reset_flag_n)
    else $error("flag high while clear is held");
  a_update_flag: assert property ((!async_update_n && async_clear_n) [*6]
      |-> reset_flag_n)
    else $error("flag not raised by async update");
  a_flag_sticky: assert property ($fell(reset_flag_n) |-> !$past(async_clear_n, 2)
      || !$past(async_clear_n, 3) || !$past(async_clear_n, 4))
    else $error("flag dropped without a clear");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
endmodule

// ### verification/qdsc_top_tb.sv
// qdsc_top_tb: register and serial scenarios for the quad dac control block
// assumes: host model drives the serial pins; bench owns register and async pins
`timescale 1ns/1ps
module qdsc_top_tb;
  import qdsc_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic async_update_n = 1'b1;
  logic async_clear_n = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic serial_clk, serial_in, select_load_n;
  logic readback_out, readback_oe, reset_flag_n, irq;
  logic [15:0] rb;
  int err_count = 0;
  int total_checks = 0;

  // 125 MHz clock
  always #4 clock = ~clock;

  qdsc_top i_qdsc_top (
    .clock(clock),
    .reset_n(reset_n),
    .serial_clk(serial_clk),
    .serial_in(serial_in),
    .select_load_n(select_load_n),
    .async_update_n(async_update_n),
    .async_clear_n(async_clear_n),
    .readback_out(readback_out),
    .readback_oe(readback_oe),
    .reset_flag_n(reset_flag_n),
    .irq(irq),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  qdsc_host_model i_host (
    .serial_clk(serial_clk),
    .serial_in(serial_in),
    .select_load_n(select_load_n),
    .readback_out(readback_out),
    .readback_oe(readback_oe)
  );

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check(nm, reg_rdata, exp);
  endtask

  // hold the update or clear pin low for n cycles
  task automatic pulse_pin(input bit upd, input int n);
    @(posedge clock);
    if (upd)
      async_update_n <= 1'b0;
    else
      async_clear_n <= 1'b0;
    repeat (n) @(posedge clock);
    async_update_n <= 1'b1;
    async_clear_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end

  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    check("flag after reset", {31'h0, reset_flag_n}, 32'h0);
    check("oe idle", {31'h0, readback_oe}, 32'h0);
    reg_check("unmapped", 8'h40, 32'h0);
    reg_check("mask reset", OFS_MASK, {29'h0, MASK_RST});
    reg_write(OFS_MASK, 32'h7);
    i_host.frame({8'h00, CMD_WR_CODE, 4'h1, 16'hA5C3}, 24, rb);
    reg_check("active code held", OFS_CODE0 + 8'h04, 32'h0);
    reg_check("status frame", OFS_STATUS, 32'h1);
    check("irq set", {31'h0, irq}, 32'h1);
    reg_write(OFS_STATUS, 32'h7);
    repeat (2) @(posedge clock);
    check("irq cleared", {31'h0, irq}, 32'h0);
    check("flag before update", {31'h0, reset_flag_n}, 32'h0);
    // long frame updates channel 1 and rolls out its holding code
    i_host.frame({8'h00, CMD_UPD_N, 4'h1, 16'h0000}, 32, rb);
    check("rolling readback", {16'h0, rb}, 32'hA5C3);
    reg_check("active code", OFS_CODE0 + 8'h04, 32'hA5C3);
    check("flag after update", {31'h0, reset_flag_n}, 32'h1);
    reg_check("status update", OFS_STATUS, 32'h3);
    reg_write(OFS_STATUS, 32'h7);
    // leading junk nibble must be dropped
    i_host.frame({4'h0, 4'hF, CMD_WR_SPAN, 4'h2, 16'h0005}, 28, rb);
    i_host.frame({8'h00, CMD_RD_B1_SPAN, 4'h2, 16'h0000}, 24, rb);
    check("span readback", {16'h0, rb}, 32'h5);
    reg_check("active span held", OFS_SPAN0 + 8'h08, 32'h0);
    pulse_pin(1'b1, 8);
    reg_check("span updated", OFS_SPAN0 + 8'h08, 32'h5);
    pulse_pin(1'b0, 8);
    check("flag after clear", {31'h0, reset_flag_n}, 32'h0);
    reg_check("code cleared", OFS_CODE0 + 8'h04, 32'h0);
    reg_check("span cleared", OFS_SPAN0 + 8'h08, 32'h0);
    reg_check("status all", OFS_STATUS, 32'h7);
    // sleep one channel, then wake every channel with a write and update
    i_host.frame({8'h00, CMD_SLEEP, 4'h2, 16'h0000}, 24, rb);
    check("rolling span", {16'h0, rb}, 32'h5);
    reg_check("sleep state", OFS_STATE, 32'h42);
    i_host.frame({8'h00, CMD_WRC_UPD_ALL, 4'h3, 16'h1234}, 24, rb);
    check("sleep bit readback", {16'h0, rb}, 32'h10);
    reg_check("code ch3 updated", OFS_CODE0 + 8'h0C, 32'h1234);
    reg_check("code ch1 updated", OFS_CODE0 + 8'h04, 32'hA5C3);
    reg_check("span ch2 updated", OFS_SPAN0 + 8'h08, 32'h5);
    reg_check("sleep woken", OFS_STATE, 32'h3);
    i_host.frame({8'h00, CMD_NOP, 4'h0, 16'h0000}, 24, rb);
    check("rolling code", {16'h0, rb}, 32'h1234);
    reg_write(OFS_STATUS, 32'h7);
    // a reserved command is ignored and raises no event
    i_host.frame({8'h00, 4'h1, 4'h1, 16'hFFFF}, 24, rb);
    reg_check("reserved ignored", OFS_STATUS, 32'h0);
    i_host.frame({8'h00, CMD_RD_B2_CODE, 4'h1, 16'h0000}, 24, rb);
    check("active readback", {16'h0, rb}, 32'hA5C3);
    check("flag stays high", {31'h0, reset_flag_n}, 32'h1);
    // a reset in mid-run lowers the flag again
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    check("flag after second reset", {31'h0, reset_flag_n}, 32'h0);
    reg_check("code after reset", OFS_CODE0 + 8'h04, 32'h0);
    report_and_stop();
  end
endmodule

bind qdsc_top qdsc_top_sva i_sva (
  .clock(clock),
  .reset_n(reset_n),
  .serial_clk(serial_clk),
  .select_load_n(select_load_n),
  .async_update_n(async_update_n),
  .async_clear_n(async_clear_n),
  .readback_out(readback_out),
  .readback_oe(readback_oe),
  .reset_flag_n(reset_flag_n),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata)
);
